//--- tb_top.sv
// Self-checking bench for the capture/PWM timer.
// Assumes the timer package and the far-side edge source model.
`timescale 1ns/1ps
module tb_top import tcpm_pkg::*;;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h00000000, prdata, rd;
    logic pready, pslverr, pin_out, pin_oe, src_level, busy, toggle = 1'b0, meas_clr = 1'b0;
    logic [15:0] high_cnt;
    int err_count = 0, checked = 0, cyc = 0, n, cnt, ld, mt, t0, t_flip;
    logic [31:0] v1;

    // ==========================================
    // Clock, pin resolution and instances.
    always #2.5 pclk = ~pclk;
    wire pin_wire = pin_oe ? pin_out : src_level;
    tcpm_timer u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .debug_halt(1'b0), .pin_in(pin_wire), .pin_out(pin_out), .pin_oe(pin_oe));
    tcpm_edge_src u_src (.pclk(pclk), .presetn(presetn), .toggle(toggle), .pin_out(pin_out),
        .pin_oe(pin_oe), .meas_clr(meas_clr), .src_level(src_level), .busy(busy), .high_cnt(high_cnt));

    // ==========================================
    // Reporting.
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            err_count++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic results();
        $display("Mismatches %0d, comparisons %0d", err_count, checked);
        if (err_count == 0 && checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // Cut a hang short; the count moves after the edge so readers see one value.
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc >= 50000) begin
            err_count++;
            results();
        end
    end

    // ==========================================
    // APB transfer: setup, then access held until pready is sampled high.
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q,
                       output logic e);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic e;
        apb(1'b1, a, d, q, e);
    endtask

    task automatic rdr(input logic [11:0] a, output logic [31:0] q);
        logic e;
        apb(1'b0, a, 32'h00000000, q, e);
    endtask

    // Flip the pin once, note the clock of the flip, and let the source finish its hold time.
    task automatic flip();
        @(posedge pclk);
        toggle <= 1'b1;
        @(posedge pclk);
        t_flip = cyc;
        toggle <= 1'b0;
        do @(posedge pclk); while (busy);
    endtask

    // Whether the new pin level after a flip is an event of the given kind.
    function automatic bit is_sel(input logic [1:0] evt, input logic lvl);
        return (evt == EVT_BOTH) || (evt == EVT_RISE && lvl) || (evt == EVT_FALL && !lvl);
    endfunction

    // Count an edge timer shows d clocks after showing v, when it wraps from zero to ilr.
    function automatic logic [31:0] cap_after(input logic [31:0] v, input int d, input int ilr);
        int per;
        per = ilr + 1;
        return (v + per - d % per) % per;
    endfunction

    // Disable, clear flags and select configuration and mode.
    task automatic setup(input logic [2:0] cfg, input logic [3:0] mode);
        wr(ADDR_CTL, 32'h00000000);
        wr(ADDR_ICR, 32'h0000000F);
        wr(ADDR_CFG, {29'h0, cfg});
        wr(ADDR_MODE, {28'h0, mode});
    endtask

    // ==========================================
    // Main sequence.
    initial begin
        logic e;
        logic [1:0] evts [3];
        evts = '{EVT_RISE, EVT_FALL, EVT_BOTH};
        v1 = $urandom(32'hC1A3);
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        // Reset values and an unmapped place.
        rdr(ADDR_ILR, rd);
        chk(rd, 32'hFFFFFFFF);
        rdr(ADDR_RIS, rd);
        chk(rd, 32'h00000000);
        apb(1'b0, 12'h0FC, 32'h00000000, rd, e);
        chk({31'h0, e}, 32'h00000001);
        // Edge count for every event kind, prescaler loaded to show it is unused.
        foreach (evts[i]) begin
            setup(CFG_16, 4'h3);
            wr(ADDR_PSC, 32'h000000FF);
            n = 1 + $urandom % 4;
            ld = 10 + $urandom % 20;
            wr(ADDR_ILR, ld);
            wr(ADDR_MATCH, ld - n);
            wr(ADDR_IMR, 32'h00000002);
            wr(ADDR_CTL, {28'h0, evts[i], 2'b01});
            cnt = 0;
            while (cnt < n) begin
                flip();
                if (is_sel(evts[i], src_level)) begin
                    cnt++;
                end
                if (cnt == n - 1 && n > 1 && is_sel(evts[i], src_level)) begin
                    rdr(ADDR_VAL, rd);
                    chk(rd, ld - cnt);
                    rdr(ADDR_RIS, rd);
                    chk(rd[1], 1'b0);
                end
            end
            rdr(ADDR_RIS, rd);
            chk(rd[1], 1'b1);
            rdr(ADDR_MIS, rd);
            chk(rd[1], 1'b1);
            rdr(ADDR_CTL, rd);
            chk(rd[0], 1'b0);
            flip();
            flip();
            rdr(ADDR_VAL, rd);
            chk(rd, ld);
            wr(ADDR_ICR, 32'h00000002);
            rdr(ADDR_RIS, rd);
            chk(rd[1], 1'b0);
        end
        // Edge time on rising edges with a short interval so the counter wraps.
        setup(CFG_16, 4'h7);
        wr(ADDR_ILR, 32'h00000040);
        wr(ADDR_IMR, 32'h00000004);
        wr(ADDR_CTL, 32'h00000001);
        if (src_level) begin
            flip();
        end
        repeat (200) @(posedge pclk);
        flip();
        t0 = t_flip;
        rdr(ADDR_RIS, rd);
        chk(rd[2], 1'b1);
        rdr(ADDR_MIS, rd);
        chk(rd[2], 1'b1);
        rdr(ADDR_VAL, v1);
        chk(v1 <= 32'h40, 1'b1);
        flip();
        repeat (17) @(posedge pclk);
        rdr(ADDR_VAL, rd);
        chk(rd, v1);
        wr(ADDR_ICR, 32'h00000004);
        rdr(ADDR_RIS, rd);
        chk(rd[2], 1'b0);
        repeat (1 + $urandom % 20) @(posedge pclk);
        flip();
        // Both captures lag their pin edges alike, so they differ by the clocks between the edges.
        rdr(ADDR_VAL, rd);
        chk(rd, cap_after(v1, t_flip - t0, 32'h40));
        rdr(ADDR_CTL, rd);
        chk(rd[0], 1'b1);
        // PWM, plain and inverted; the prescaler still holds its largest value.
        for (int inv = 0; inv < 2; inv++) begin
            setup(CFG_16, 4'hA);
            ld = 8 + $urandom % 40;
            mt = 1 + $urandom % (ld - 1);
            wr(ADDR_ILR, ld);
            wr(ADDR_MATCH, mt);
            wr(ADDR_IMR, 32'h0000000F);
            wr(ADDR_CTL, 32'h00000001 | (inv << 5));
            repeat (3 * (ld + 1)) @(posedge pclk);
            chk(pin_oe, 1'b1);
            meas_clr <= 1'b1;
            @(posedge pclk);
            meas_clr <= 1'b0;
            repeat (ld + 1) @(posedge pclk);
            #1;
            chk(high_cnt, inv ? mt + 1 : ld - mt);
            rdr(ADDR_RIS, rd);
            chk(rd, 32'h00000000);
        end
        // 32-bit one-shot then periodic.
        for (int m = 1; m < 3; m++) begin
            setup(CFG_32, m[3:0]);
            wr(ADDR_ILR, 32'h00000014);
            wr(ADDR_IMR, 32'h00000001);
            wr(ADDR_CTL, 32'h00000001);
            rd = 32'h0;
            for (int k = 0; k < 40 && rd[0] !== 1'b1; k++) begin
                rdr(ADDR_RIS, rd);
            end
            chk(rd[0], 1'b1);
            rdr(ADDR_CTL, rd);
            chk(rd[0], m == 2);
            wr(ADDR_ICR, 32'h00000001);
            rdr(ADDR_RIS, rd);
            chk(rd[0], 1'b0);
            repeat (60) @(posedge pclk);
            rdr(ADDR_RIS, rd);
            chk(rd[0], m == 2);
        end
        // 16-bit one-shot: a prescale of nine stretches each count to ten clocks, fifty in all.
        setup(CFG_16, {2'b00, MODE_ONESHOT});
        wr(ADDR_PSC, 32'h00000009);
        wr(ADDR_ILR, 32'h00000004);
        wr(ADDR_IMR, 32'h00000001);
        wr(ADDR_CTL, 32'h00000001);
        repeat (30) @(posedge pclk);
        rdr(ADDR_RIS, rd);
        chk(rd[0], 1'b0);
        repeat (30) @(posedge pclk);
        rdr(ADDR_RIS, rd);
        chk(rd[0], 1'b1);
        rdr(ADDR_CTL, rd);
        chk(rd[0], 1'b0);
        // Real-time clock set up in order; one tick needs more pin clocks than a run allows.
        wr(ADDR_CTL, 32'h00000000);
        wr(ADDR_CFG, {29'h0, CFG_RTC});
        wr(ADDR_MATCH, 32'h00000005);
        wr(ADDR_CTL, 32'h00000010);
        wr(ADDR_IMR, 32'h00000008);
        wr(ADDR_CTL, 32'h00000011);
        repeat (4) flip();
        rdr(ADDR_VAL, rd);
        chk(rd, RTC_FIRST);
        rdr(ADDR_RIS, rd);
        chk(rd[3], 1'b0);
        results();
    end
endmodule

//--- tcpm_edge_src.sv
// Far-side model of the capture pin: an edge source and a PWM load.
// Assumes the bench pulses toggle for one clock and waits while busy.
`timescale 1ns/1ps
// ==========================================
// Edge source and duty-cycle meter.
module tcpm_edge_src #(parameter int HOLD = 6) (
    input wire logic pclk, // System clock.
    input wire logic presetn, // Asynchronous reset, active low.
    input wire logic toggle, // Request to flip the driven level.
    input wire logic pin_out, // PWM level from the timer.
    input wire logic pin_oe, // PWM drive enable from the timer.
    input wire logic meas_clr, // Clears the high-cycle meter.
    output logic src_level, // Level this source drives.
    output logic busy, // High while a level must still be held.
    output logic [15:0] high_cnt // Clocks seen with the PWM line driven high.
);
    logic [7:0] hold_r; // Clocks left before the next flip is allowed.

    // Flip the level and hold it well past two clocks so no edge is lost.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            src_level <= 1'b0;
            hold_r <= 8'h00;
            high_cnt <= 16'h0000;
        end else begin
            if (toggle && hold_r == 8'h00) begin
                src_level <= ~src_level;
                hold_r <= HOLD[7:0];
            end else if (hold_r != 8'h00) begin
                hold_r <= hold_r - 8'h01;
            end
            // The meter counts only while the timer really drives the pin.
            if (meas_clr) begin
                high_cnt <= 16'h0000;
            end else if (pin_oe && pin_out) begin
                high_cnt <= high_cnt + 16'h0001;
            end
        end
    end

    assign busy = (hold_r != 8'h00) || toggle;
endmodule

//--- tcpm_pkg.sv
// Constants, register offsets and field layouts for the capture/PWM timer.
// Assumes an APB master on pclk and a capture pin synchronous to nothing.
package tcpm_pkg;
    // ==========================================
    // Register byte offsets.
    localparam logic [11:0] ADDR_CFG = 12'h000;
    localparam logic [11:0] ADDR_MODE = 12'h004;
    localparam logic [11:0] ADDR_CTL = 12'h00C;
    localparam logic [11:0] ADDR_IMR = 12'h018;
    localparam logic [11:0] ADDR_RIS = 12'h01C;
    localparam logic [11:0] ADDR_MIS = 12'h020;
    localparam logic [11:0] ADDR_ICR = 12'h024;
    localparam logic [11:0] ADDR_ILR = 12'h028;
    localparam logic [11:0] ADDR_MATCH = 12'h030;
    localparam logic [11:0] ADDR_PSC = 12'h038;
    localparam logic [11:0] ADDR_VAL = 12'h048;
    // ==========================================
    // Configuration, mode and event encodings.
    localparam logic [2:0] CFG_32 = 3'h0;
    localparam logic [2:0] CFG_RTC = 3'h1;
    localparam logic [2:0] CFG_16 = 3'h4;
    localparam logic [1:0] MODE_ONESHOT = 2'h1;
    localparam logic [1:0] MODE_PERIODIC = 2'h2;
    localparam logic [1:0] MODE_CAPTURE = 2'h3;
    localparam logic [1:0] EVT_RISE = 2'h0;
    localparam logic [1:0] EVT_FALL = 2'h1;
    localparam logic [1:0] EVT_BOTH = 2'h3;
    // Flag bit positions in mask, raw, masked and clear registers.
    localparam int FLG_TO = 0;
    localparam int FLG_CM = 1;
    localparam int FLG_CE = 2;
    localparam int FLG_RTC = 3;
    // ==========================================
    // Reset values and the real-time clock divider.
    localparam logic [31:0] LOAD_RST = 32'hFFFFFFFF;
    localparam logic [31:0] RTC_FIRST = 32'h00000001;
    localparam logic [14:0] RTC_DIV_LAST = 15'h7FFF;
    // Mode register layout.
    typedef struct packed {
        logic ams;
        logic cmr;
        logic [1:0] mode;
    } tcpm_mode_type;
    // Control register layout.
    typedef struct packed {
        logic pwml;
        logic rtc_ovr;
        logic [1:0] evt;
        logic stall;
        logic en;
    } tcpm_ctl_type;
endpackage

//--- tcpm_timer.sv
// General-purpose timer with edge count, edge time, PWM and timer modes.
// Assumes an APB master on pclk and the capture pin as an input that this timer drives in PWM mode.
`timescale 1ns/1ps
module tcpm_timer import tcpm_pkg::*; (
    input wire logic pclk, // System clock, 200 MHz.
    input wire logic presetn, // Asynchronous reset, active low.
    input wire logic psel, // APB select.
    input wire logic penable, // APB access phase.
    input wire logic pwrite, // APB write direction.
    input wire logic [11:0] paddr, // APB byte address.
    input wire logic [31:0] pwdata, // APB write data.
    output logic [31:0] prdata, // APB read data.
    output logic pready, // APB ready.
    output logic pslverr, // APB error on unmapped address.
    input wire logic debug_halt, // Processor halted by debugger.
    input wire logic pin_in, // Capture pin input.
    output logic pin_out, // Capture pin PWM drive.
    output logic pin_oe // Capture pin output enable.
);
    // ==========================================
    // State.
    logic [2:0] cfg_r, cfg_nxt; // Configuration.
    tcpm_mode_type mode_r, mode_nxt; // Mode register.
    tcpm_ctl_type ctl_r, ctl_nxt; // Control register.
    logic [3:0] imr_r, imr_nxt; // Interrupt mask.
    logic [3:0] ris_r, ris_nxt; // Raw flags.
    logic [31:0] ilr_r, ilr_nxt; // Interval load.
    logic [31:0] match_r, match_nxt; // Match value.
    logic [7:0] pr_r, pr_nxt; // Prescale load.
    logic [7:0] psc_r, psc_nxt; // Prescale count.
    logic [31:0] cnt_r, cnt_nxt; // Main counter.
    logic [15:0] cap_r, cap_nxt; // Captured count.
    logic [14:0] div_r, div_nxt; // Real-time clock divider.
    logic sync1_r, sync2_r, prev_r; // Pin synchroniser.
    logic pwm_r, pwm_nxt; // PWM output level.
    logic oe_r, oe_nxt; // Pin output enable.
    logic [31:0] prdata_r, prdata_nxt; // Read data.
    logic pready_r, pready_nxt; // Ready.
    logic pslverr_r, pslverr_nxt; // Error.
    // Decoded conditions.
    logic wr, rd, is16, wide, cap_mode, pwm_mode, tmr_mode, rtc_mode;
    logic rise, fall, hit, halt, mapped;

    // Decrements at the active width.
    function automatic logic [31:0] dec(input logic [31:0] c, input logic w);
        dec = w ? c - 32'h1 : {16'h0, c[15:0] - 16'h1};
    endfunction

    // True when the counter is zero at the active width.
    function automatic logic zero(input logic [31:0] c, input logic w);
        zero = w ? (c == 32'h0) : (c[15:0] == 16'h0);
    endfunction

    // Register file membership of an address.
    function automatic logic known(input logic [11:0] a);
        known = (a == ADDR_CFG) || (a == ADDR_MODE) || (a == ADDR_CTL) ||
                (a == ADDR_IMR) || (a == ADDR_RIS) || (a == ADDR_MIS) ||
                (a == ADDR_ICR) || (a == ADDR_ILR) || (a == ADDR_MATCH) ||
                (a == ADDR_PSC) || (a == ADDR_VAL);
    endfunction

    // ==========================================
    // Mode decode and edge detection.
    always_comb begin
        wr = psel && penable && pwrite && pready_r;
        rd = psel && !penable && !pwrite;
        mapped = known(paddr);
        is16 = (cfg_r == CFG_16);
        wide = !is16;
        rtc_mode = (cfg_r == CFG_RTC);
        cap_mode = is16 && !mode_r.ams && (mode_r.mode == MODE_CAPTURE);
        pwm_mode = is16 && mode_r.ams && !mode_r.cmr && (mode_r.mode == MODE_PERIODIC);
        tmr_mode = ((cfg_r == CFG_32) || (is16 && !mode_r.ams)) &&
                   ((mode_r.mode == MODE_ONESHOT) || (mode_r.mode == MODE_PERIODIC));
        rise = sync2_r && !prev_r;
        fall = !sync2_r && prev_r;
        case (ctl_r.evt)
            EVT_RISE: hit = rise;
            EVT_FALL: hit = fall;
            EVT_BOTH: hit = rise || fall;
            default: hit = rise;
        endcase
        halt = ctl_r.stall && debug_halt && !(rtc_mode && ctl_r.rtc_ovr);
    end

    // ==========================================
    // Next state of registers, counter and outputs.
    always_comb begin
        cfg_nxt = cfg_r;
        mode_nxt = mode_r;
        ctl_nxt = ctl_r;
        imr_nxt = imr_r;
        ris_nxt = ris_r;
        ilr_nxt = ilr_r;
        match_nxt = match_r;
        pr_nxt = pr_r;
        psc_nxt = psc_r;
        cnt_nxt = cnt_r;
        cap_nxt = cap_r;
        div_nxt = div_r;
        pwm_nxt = pwm_r;
        oe_nxt = pwm_mode;
        // Software writes land first; hardware events below override them.
        if (wr) begin
            case (paddr)
                ADDR_CFG: begin
                    cfg_nxt = pwdata[2:0];
                    if (pwdata[2:0] == CFG_RTC) begin
                        cnt_nxt = RTC_FIRST;
                        div_nxt = '0;
                    end
                end
                ADDR_MODE: mode_nxt = pwdata[3:0];
                ADDR_CTL: ctl_nxt = pwdata[5:0];
                ADDR_IMR: imr_nxt = pwdata[3:0];
                ADDR_ICR: ris_nxt = ris_r & ~pwdata[3:0];
                ADDR_ILR: begin
                    ilr_nxt = pwdata;
                    // A running timer takes a new interval at once only while halted or mid 16-bit prescale, else at its next reload;
                    // edge count waits for its reload too, and a running real-time clock never takes it.
                    if (ctl_r.en && !rtc_mode && !(cap_mode && !mode_r.cmr)) begin
                        cnt_nxt = wide ? pwdata : {16'h0, pwdata[15:0]};
                    end else if (!ctl_r.en) begin
                        cnt_nxt = wide ? pwdata : {16'h0, pwdata[15:0]};
                    end
                end
                ADDR_MATCH: match_nxt = pwdata;
                ADDR_PSC: begin
                    pr_nxt = pwdata[7:0];
                    psc_nxt = pwdata[7:0];
                end
                default: begin
                end
            endcase
        end
        if (ctl_r.en && !halt) begin
            if (tmr_mode) begin
                // Prescaler only extends plain 16-bit timing.
                if (is16 && (psc_r != 8'h0)) begin
                    psc_nxt = psc_r - 8'h1;
                end else if (zero(cnt_r, wide)) begin
                    cnt_nxt = wide ? ilr_r : {16'h0, ilr_r[15:0]};
                    psc_nxt = pr_r;
                    ris_nxt[FLG_TO] = 1'b1;
                    if (mode_r.mode == MODE_ONESHOT) begin
                        ctl_nxt.en = 1'b0;
                    end
                end else begin
                    cnt_nxt = dec(cnt_r, wide);
                    psc_nxt = pr_r;
                end
            end else if (cap_mode && !mode_r.cmr) begin
                // Counts selected edges only, no prescaler.
                if (hit) begin
                    if (dec(cnt_r, 1'b0) == {16'h0, match_r[15:0]}) begin
                        cnt_nxt = {16'h0, ilr_r[15:0]};
                        ctl_nxt.en = 1'b0;
                        ris_nxt[FLG_CM] = 1'b1;
                    end else begin
                        cnt_nxt = dec(cnt_r, 1'b0);
                    end
                end
            end else if (cap_mode) begin
                // Free-running edge timer.
                cnt_nxt = zero(cnt_r, 1'b0) ? {16'h0, ilr_r[15:0]} : dec(cnt_r, 1'b0);
                if (hit) begin
                    cap_nxt = cnt_r[15:0];
                    ris_nxt[FLG_CE] = 1'b1;
                end
            end else if (pwm_mode) begin
                cnt_nxt = zero(cnt_r, 1'b0) ? {16'h0, ilr_r[15:0]} : dec(cnt_r, 1'b0);
                if (cnt_r[15:0] == ilr_r[15:0]) begin
                    pwm_nxt = !ctl_r.pwml;
                end else if (cnt_r[15:0] == match_r[15:0]) begin
                    pwm_nxt = ctl_r.pwml;
                end
            end else if (rtc_mode && rise) begin
                // Divide the pin clock down to one tick a second.
                div_nxt = div_r + 15'h1;
                if (div_r == RTC_DIV_LAST) begin
                    if (cnt_r == match_r) begin
                        cnt_nxt = 32'h0;
                        ris_nxt[FLG_RTC] = 1'b1;
                    end else begin
                        cnt_nxt = cnt_r + 32'h1;
                    end
                end
            end
        end
        if (!pwm_mode) begin
            pwm_nxt = 1'b0;
        end
    end

    // ==========================================
    // APB answer: decoded in setup, ready in the first access cycle.
    always_comb begin
        pready_nxt = psel && !penable;
        pslverr_nxt = psel && !penable && !mapped;
        prdata_nxt = 32'h0;
        if (rd) begin
            case (paddr)
                ADDR_CFG: prdata_nxt = {29'h0, cfg_r};
                ADDR_MODE: prdata_nxt = {28'h0, mode_r};
                ADDR_CTL: prdata_nxt = {26'h0, ctl_r};
                ADDR_IMR: prdata_nxt = {28'h0, imr_r};
                ADDR_RIS: prdata_nxt = {28'h0, ris_r};
                ADDR_MIS: prdata_nxt = {28'h0, ris_r & imr_r};
                ADDR_ILR: prdata_nxt = ilr_r;
                ADDR_MATCH: prdata_nxt = match_r;
                ADDR_PSC: prdata_nxt = {24'h0, pr_r};
                ADDR_VAL: prdata_nxt = cap_mode && mode_r.cmr ? {16'h0, cap_r} : cnt_r;
                default: prdata_nxt = 32'h0;
            endcase
        end
    end

    // ==========================================
    // Registers.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg_r <= CFG_32;
            mode_r <= '0;
            ctl_r <= '0;
            imr_r <= '0;
            ris_r <= '0;
            ilr_r <= LOAD_RST;
            match_r <= LOAD_RST;
            pr_r <= '0;
            psc_r <= '0;
            cnt_r <= LOAD_RST;
            cap_r <= '0;
            div_r <= '0;
            sync1_r <= 1'b0;
            sync2_r <= 1'b0;
            prev_r <= 1'b0;
            pwm_r <= 1'b0;
            oe_r <= 1'b0;
            prdata_r <= '0;
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
        end else begin
            cfg_r <= cfg_nxt;
            mode_r <= mode_nxt;
            ctl_r <= ctl_nxt;
            imr_r <= imr_nxt;
            ris_r <= ris_nxt;
            ilr_r <= ilr_nxt;
            match_r <= match_nxt;
            pr_r <= pr_nxt;
            psc_r <= psc_nxt;
            cnt_r <= cnt_nxt;
            cap_r <= cap_nxt;
            div_r <= div_nxt;
            sync1_r <= pin_in;
            sync2_r <= sync1_r;
            prev_r <= sync2_r;
            pwm_r <= pwm_nxt;
            oe_r <= oe_nxt;
            prdata_r <= prdata_nxt;
            pready_r <= pready_nxt;
            pslverr_r <= pslverr_nxt;
        end
    end

    assign prdata = prdata_r;
    assign pready = pready_r;
    assign pslverr = pslverr_r;
    assign pin_out = pwm_r;
    assign pin_oe = oe_r;

    // ==========================================
    // Assertions.
    property p_edge_dec;
        @(posedge pclk) disable iff (!presetn)
        cap_mode && !mode_r.cmr && ctl_r.en && !halt && hit && !wr &&
        (dec(cnt_r, 1'b0) != {16'h0, match_r[15:0]}) |=> cnt_r[15:0] == $past(cnt_r[15:0]) - 16'h1;
    endproperty
    a_edge_dec: assert property (p_edge_dec) else $error("edge count did not step by one");

    property p_match_stop;
        @(posedge pclk) disable iff (!presetn)
        $rose(ris_r[FLG_CM]) && cap_mode |-> !ctl_r.en && cnt_r[15:0] == ilr_r[15:0];
    endproperty
    a_match_stop: assert property (p_match_stop) else $error("match did not reload and stop");

    property p_idle_hold;
        @(posedge pclk) disable iff (!presetn)
        cap_mode && !mode_r.cmr && !ctl_r.en && !wr |=> $stable(cnt_r);
    endproperty
    a_idle_hold: assert property (p_idle_hold) else $error("disabled edge counter moved");

    property p_capture;
        @(posedge pclk) disable iff (!presetn)
        cap_mode && mode_r.cmr && ctl_r.en && !halt && hit |=> cap_r == $past(cnt_r[15:0]) && ris_r[FLG_CE];
    endproperty
    a_capture: assert property (p_capture) else $error("edge time capture missing");

    property p_pwm_quiet;
        @(posedge pclk) disable iff (!presetn)
        pwm_mode && !wr |=> ris_r == $past(ris_r);
    endproperty
    a_pwm_quiet: assert property (p_pwm_quiet) else $error("flag changed in PWM mode");

    property p_pwm_on;
        @(posedge pclk) disable iff (!presetn)
        pwm_mode && ctl_r.en && !halt && !wr && cnt_r[15:0] == ilr_r[15:0] |=> pin_out == !$past(ctl_r.pwml);
    endproperty
    a_pwm_on: assert property (p_pwm_on) else $error("PWM not active at start value");

    property p_clear;
        @(posedge pclk) disable iff (!presetn)
        wr && paddr == ADDR_ICR && pwdata[FLG_TO] && !(tmr_mode && ctl_r.en) |=> !ris_r[FLG_TO];
    endproperty
    a_clear: assert property (p_clear) else $error("timeout flag not cleared");

    property p_oneshot;
        @(posedge pclk) disable iff (!presetn)
        tmr_mode && mode_r.mode == MODE_ONESHOT && ctl_r.en && !halt && !wr &&
        zero(cnt_r, wide) && (!is16 || psc_r == 8'h0) |=> !ctl_r.en ##0 ris_r[FLG_TO];
    endproperty
    a_oneshot: assert property (p_oneshot) else $error("one-shot kept running");
endmodule
